// ===== fsk_fmt_defs.svh
// constants shared by both ends of the fsk block formatter
`ifndef FSK_FMT_DEFS_SVH
`define FSK_FMT_DEFS_SVH
// block command word fields
`define CMD_F_OP 15:12
`define CMD_F_TYPE 11:8
`define CMD_B_RX 7
`define CMD_B_EOT 6
// block commands
`define CMD_STATION 4'h4
`define CMD_HEADER 4'h5
`define CMD_INTER 4'h6
`define CMD_LAST 4'h7
`define CMD_RESTART 4'h8
// block types
`define TYPE_LEGACY 4'h3
`define TYPE_MAX 4'hb
// frame layout
`define FS_SYMBOLS 8'h18
`define SYM_SYNC_BYTES 4'h4
`define SYM_SYNC_BYTE 8'h77
`define HDR_CSUM_BYTES 3'h2
`define LAST_CSUM_BYTES 3'h4
`define SID_USER_BYTES 6'h03
`define SID_CSUM_BYTES 3'h1
// host register word addresses
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_TXD 4'h2
`define REG_RXD 4'h3
`define REG_STAT 4'h4
`define REG_INIT_SID 4'h5
`define REG_INIT_HDR 4'h6
`define REG_INIT_PAY 4'h7
// reset values of the checksum start values
`define INIT_RESET 32'h0000_0000
`endif

// ===== fsk_fmt_pkg.sv
// types shared by both ends of the fsk block formatter
package fsk_fmt_pkg;
  typedef enum logic [1:0] {MOD_4FSK, MOD_8FSK, MOD_16FSK} mod_t;
  typedef enum logic [2:0] {RATE_NONE, RATE_3_4, RATE_2_3, RATE_9_16, RATE_1_2} rate_t;
  typedef enum logic [2:0] {PH_IDLE, PH_SYM, PH_FS, PH_STAT, PH_USER, PH_CSUM} phase_t;
endpackage : fsk_fmt_pkg

// ===== fsk_fmt_if.sv
// link between the host controller and the block formatter
interface fsk_fmt_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [15:0] cmd_word;
  fsk_fmt_pkg::mod_t mod_sel;
  logic [5:0] init_sid;
  logic [15:0] init_hdr;
  logic [31:0] init_pay;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] h2d_data;
  logic d2h_valid;
  logic d2h_ready;
  logic d2h_last;
  logic [7:0] d2h_data;
  logic crc_done;
  logic crc_pass;
  logic cmd_err;
  modport dev (input cmd_valid, cmd_word, mod_sel, init_sid, init_hdr, init_pay,
    input h2d_valid, h2d_data, d2h_ready,
    output cmd_ready, h2d_ready, d2h_valid, d2h_last, d2h_data, crc_done, crc_pass, cmd_err);
  modport host (output cmd_valid, cmd_word, mod_sel, init_sid, init_hdr, init_pay,
    output h2d_valid, h2d_data, d2h_ready,
    input cmd_ready, h2d_ready, d2h_valid, d2h_last, d2h_data, crc_done, crc_pass, cmd_err);
endinterface : fsk_fmt_if

// ===== fsk_fmt_crc.sv
// byte-serial checksum generator with loadable start value
module fsk_fmt_crc #(
  parameter int W = 16,
  parameter logic [W-1:0] POLY = '1
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_reset, // sync reset, active high
  input wire logic i_ce, // clock enable
  input wire logic i_clear, // load start value
  input wire logic [W-1:0] i_init, // start value
  input wire logic i_en, // fold in one byte
  input wire logic [7:0] i_byte, // byte to fold in, msb first
  output logic [W-1:0] o_crc // running checksum
);
  logic [W-1:0] crc_r;
  logic [W-1:0] crc_nxt;

  // shift eight bits through the polynomial divider
  always_comb
  begin
    crc_nxt = crc_r;
    for (int i = 7; i >= 0; i--)
    begin
      crc_nxt = (crc_nxt[W-1] ^ i_byte[i]) ? ((crc_nxt << 1) ^ POLY) : (crc_nxt << 1);
    end
  end

  // clear has priority over folding
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      crc_r <= '0;
    else if (i_ce && i_clear)
      crc_r <= i_init;
    else if (i_ce && i_en)
      crc_r <= crc_nxt;
  end

  assign o_crc = crc_r;
endmodule : fsk_fmt_crc

// ===== fsk_fmt_dev.sv
// modem end of the fsk block formatter: frames, codes and checks blocks
// Overview of operation
// - 4-FSK offers native and legacy coded modes
// - legacy blocks refused unless 4-FSK selected
// - native sizes, high or low rate each
// - native frame: 24-symbol sync, header, blocks
// - header checksum covers only its bytes
// - running checksum over intermediate and last
// - restart block clears running checksum
// - only plain payload crosses the host link
// - native header/last report pass, still deliver
// - type field bits 11-8 picks block size
// - code rate per type and modulation
// - user bytes: size-2, size, size-4
// - legacy frame: sync, station identity, blocks
// - symbol sync once per legacy transmission
// - legacy identity 6-bit, header 16-bit checksums
// - legacy running checksum is 32 bits
// - legacy identity/header/last report pass, deliver
// - legacy blocks lead with one status byte
// - identity block: status plus three bytes
// - host sets checksum start values to zero
//
// The implementer's own choices: the address map and the plain strobed port.
`include "fsk_fmt_defs.svh"
module fsk_fmt_dev #(
  parameter logic [95:0] FS_PATTERN = 96'h5555_5555_5555_5555_5555_5555, // sync, low byte last
  parameter logic [7:0] CODE_INIT = 8'h00, // coder start state
  parameter logic [5:0] SID_POLY = 6'h03, // identity checksum polynomial
  parameter logic [15:0] HDR_POLY = 16'h1021, // header checksum polynomial
  parameter logic [31:0] PAY_POLY = 32'h04c1_1db7 // running checksum polynomial
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_reset, // sync reset, active high
  input wire logic i_ce, // clock enable
  fsk_fmt_if.dev bus, // host link
  output logic o_air_valid, // coded byte to modulator
  output logic [7:0] o_air_data, // coded byte
  input wire logic i_air_ready, // modulator takes byte
  input wire logic i_air_valid, // coded byte from demodulator
  input wire logic [7:0] i_air_data, // received coded byte
  output logic o_air_ready, // formatter takes received byte
  output fsk_fmt_pkg::rate_t o_code_rate, // rate of current block
  output logic o_legacy // current block is legacy format
);
  // predefined block size in bytes per type
  function automatic logic [5:0] blk_size(input logic [3:0] t);
    case (t)
      4'h0: blk_size = 6'h06;
      4'h1: blk_size = 6'h09;
      4'h5, 4'h9: blk_size = 6'h18;
      4'h6, 4'ha: blk_size = 6'h24;
      4'h7, 4'hb: blk_size = 6'h30;
      default: blk_size = 6'h0c;
    endcase
  endfunction : blk_size

  // appended checksum bytes per command
  function automatic logic [2:0] csum_len(input logic [3:0] op);
    case (op)
      `CMD_HEADER: csum_len = `HDR_CSUM_BYTES;
      `CMD_LAST: csum_len = `LAST_CSUM_BYTES;
      `CMD_STATION: csum_len = `SID_CSUM_BYTES;
      default: csum_len = 3'h0;
    endcase
  endfunction : csum_len

  // bytes taken by the 24-symbol frame sync, less one
  function automatic logic [5:0] fs_last(input fsk_fmt_pkg::mod_t m);
    case (m)
      fsk_fmt_pkg::MOD_8FSK: fs_last = 6'(((`FS_SYMBOLS * 3) / 8) - 1);
      fsk_fmt_pkg::MOD_16FSK: fs_last = 6'(((`FS_SYMBOLS * 4) / 8) - 1);
      default: fs_last = 6'(((`FS_SYMBOLS * 2) / 8) - 1);
    endcase
  endfunction : fs_last

  // code rate by type group and modulation
  function automatic fsk_fmt_pkg::rate_t rate_of(input logic [3:0] t, input fsk_fmt_pkg::mod_t m);
    if (t >= 4'h8)
      rate_of = (m == fsk_fmt_pkg::MOD_8FSK) ? fsk_fmt_pkg::RATE_1_2 : fsk_fmt_pkg::RATE_9_16;
    else
      rate_of = (m == fsk_fmt_pkg::MOD_8FSK) ? fsk_fmt_pkg::RATE_2_3 : fsk_fmt_pkg::RATE_3_4;
  endfunction : rate_of

  fsk_fmt_pkg::phase_t ph_r, ph_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] ulen_r;
  logic [2:0] clen_r;
  logic [3:0] op_r;
  logic rx_r, eot_r, leg_r, in_tx_r, mism_r;
  logic [7:0] code_r;
  logic air_v_r, host_v_r, host_l_r, done_r, pass_r, err_r;
  logic [7:0] air_d_r, host_d_r;
  fsk_fmt_pkg::rate_t rate_r;
  logic [5:0] sid_crc;
  logic [15:0] hdr_crc;
  logic [31:0] pay_crc;

  // command decode and legality
  wire [3:0] op = bus.cmd_word[`CMD_F_OP];
  wire [3:0] ty = bus.cmd_word[`CMD_F_TYPE];
  wire cmd_rx = bus.cmd_word[`CMD_B_RX];
  wire idle = (ph_r == fsk_fmt_pkg::PH_IDLE);
  wire accept = i_ce && idle && bus.cmd_valid;
  wire legacy_cmd = (ty == `TYPE_LEGACY) || (op == `CMD_STATION);
  wire op_ok = (op >= `CMD_STATION) && (op <= `CMD_RESTART);
  wire type_ok = (ty <= `TYPE_MAX) || (op == `CMD_STATION) || (op == `CMD_RESTART);
  wire mod_ok = !legacy_cmd || (bus.mod_sel == fsk_fmt_pkg::MOD_4FSK);
  wire cmd_ok = op_ok && type_ok && mod_ok;
  wire go = accept && cmd_ok && (op != `CMD_RESTART);
  wire restart = accept && cmd_ok && (op == `CMD_RESTART);
  wire frame_start = ((op == `CMD_HEADER) && !legacy_cmd) || (op == `CMD_STATION);
  // header size-2, last size-4, intermediate whole; identity three bytes
  wire [5:0] ulen = (op == `CMD_STATION) ? `SID_USER_BYTES
                  : 6'(blk_size(ty) - {3'h0, csum_len(op)});

  // byte stream steering
  wire ph_data = (ph_r == fsk_fmt_pkg::PH_STAT) || (ph_r == fsk_fmt_pkg::PH_USER);
  wire ph_csum = (ph_r == fsk_fmt_pkg::PH_CSUM);
  wire src_need = ph_data || (rx_r && ph_csum);
  wire sink_need = rx_r ? ph_data : !idle;
  wire air_free = !air_v_r || i_air_ready;
  wire host_free = !host_v_r || bus.d2h_ready;
  wire sink_ok = !sink_need || (rx_r ? host_free : air_free);
  wire src_ok = !src_need || (rx_r ? i_air_valid : bus.h2d_valid);
  wire step = i_ce && !idle && src_ok && sink_ok;
  wire [7:0] din = rx_r ? i_air_data : bus.h2d_data;
  wire [31:0] csw = (op_r == `CMD_HEADER) ? {16'h0000, hdr_crc}
                  : (op_r == `CMD_STATION) ? {26'h0, sid_crc} : pay_crc;
  wire [7:0] csum_byte = csw[8 * cnt_r[1:0] +: 8];
  wire [7:0] dec = din ^ code_r;
  wire [7:0] tx_byte = (ph_r == fsk_fmt_pkg::PH_SYM) ? `SYM_SYNC_BYTE
                     : (ph_r == fsk_fmt_pkg::PH_FS) ? FS_PATTERN[8 * cnt_r[3:0] +: 8]
                     : ph_csum ? (csum_byte ^ code_r) : (din ^ code_r);
  wire bad = ph_csum && (dec != csum_byte);
  wire last_step = step && ph_csum && (cnt_r == 6'h00);
  wire crc_fold = step && (ph_r == fsk_fmt_pkg::PH_USER);
  wire [7:0] plain = rx_r ? dec : din;

  // ready terms stall the source until the sink has room
  assign bus.cmd_ready = i_ce && idle;
  assign bus.h2d_ready = i_ce && !rx_r && ph_data && air_free;
  assign o_air_ready = i_ce && rx_r && src_need && (!ph_data || host_free);

  // phase sequencing
  always_comb
  begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    if (go)
    begin
      if (!cmd_rx && frame_start && legacy_cmd && !in_tx_r)
      begin
        ph_nxt = fsk_fmt_pkg::PH_SYM;
        cnt_nxt = 6'(`SYM_SYNC_BYTES - 1);
      end
      else if (!cmd_rx && frame_start)
      begin
        ph_nxt = fsk_fmt_pkg::PH_FS;
        cnt_nxt = fs_last(bus.mod_sel);
      end
      else
      begin
        ph_nxt = legacy_cmd ? fsk_fmt_pkg::PH_STAT : fsk_fmt_pkg::PH_USER;
        cnt_nxt = legacy_cmd ? 6'h00 : 6'(ulen - 6'h01);
      end
    end
    else if (step)
    begin
      case (ph_r)
        fsk_fmt_pkg::PH_SYM:
        begin
          ph_nxt = (cnt_r == 6'h00) ? fsk_fmt_pkg::PH_FS : ph_r;
          cnt_nxt = (cnt_r == 6'h00) ? fs_last(bus.mod_sel) : 6'(cnt_r - 6'h01);
        end
        fsk_fmt_pkg::PH_FS, fsk_fmt_pkg::PH_STAT:
        begin
          if (cnt_r != 6'h00)
            cnt_nxt = 6'(cnt_r - 6'h01);
          else if (leg_r && ph_r == fsk_fmt_pkg::PH_FS)
            ph_nxt = fsk_fmt_pkg::PH_STAT;
          else
          begin
            ph_nxt = fsk_fmt_pkg::PH_USER;
            cnt_nxt = 6'(ulen_r - 6'h01);
          end
        end
        fsk_fmt_pkg::PH_USER:
        begin
          if (cnt_r != 6'h00)
            cnt_nxt = 6'(cnt_r - 6'h01);
          else
          begin
            ph_nxt = (clen_r != 3'h0) ? fsk_fmt_pkg::PH_CSUM : fsk_fmt_pkg::PH_IDLE;
            cnt_nxt = 6'({3'h0, clen_r} - 6'h01);
          end
        end
        fsk_fmt_pkg::PH_CSUM:
        begin
          ph_nxt = (cnt_r == 6'h00) ? fsk_fmt_pkg::PH_IDLE : ph_r;
          cnt_nxt = 6'(cnt_r - 6'h01);
        end
        default: ph_nxt = fsk_fmt_pkg::PH_IDLE;
      endcase
    end
  end

  // phase, counter and latched command
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ph_r <= fsk_fmt_pkg::PH_IDLE;
      cnt_r <= 6'h00;
      {op_r, ulen_r, clen_r, rx_r, eot_r, leg_r} <= '0;
      rate_r <= fsk_fmt_pkg::RATE_NONE;
    end
    else if (i_ce)
    begin
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      if (go)
      begin
        {op_r, ulen_r, clen_r} <= {op, ulen, csum_len(op)};
        {rx_r, eot_r, leg_r} <= {cmd_rx, bus.cmd_word[`CMD_B_EOT], legacy_cmd};
        rate_r <= rate_of(ty, bus.mod_sel);
      end
    end
  end

  // transmission tracking, coder state and checksum compare
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      {in_tx_r, mism_r, code_r} <= '0;
    else if (i_ce)
    begin
      if (go && !cmd_rx && frame_start && legacy_cmd)
        in_tx_r <= 1'b1;
      else if (last_step && !rx_r && eot_r && op_r == `CMD_LAST)
        in_tx_r <= 1'b0;
      if (go)
        {mism_r, code_r} <= {1'b0, CODE_INIT};
      else if (step && (ph_data || ph_csum))
      begin
        code_r <= rx_r ? din : tx_byte;
        mism_r <= mism_r | (rx_r && bad);
      end
    end
  end

  // registered byte outputs and result flags
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      {air_v_r, air_d_r, host_v_r, host_d_r, host_l_r, done_r, pass_r, err_r} <= '0;
    else if (i_ce)
    begin
      if (step && !rx_r)
        {air_v_r, air_d_r} <= {1'b1, tx_byte};
      else if (i_air_ready)
        air_v_r <= 1'b0;
      if (step && rx_r && ph_data)
        {host_v_r, host_d_r, host_l_r} <= {1'b1, dec, ph_r == fsk_fmt_pkg::PH_USER && cnt_r == 6'h00};
      else if (bus.d2h_ready)
        host_v_r <= 1'b0;
      done_r <= last_step && rx_r;
      if (last_step && rx_r)
        pass_r <= !(mism_r || bad);
      err_r <= accept && !cmd_ok;
    end
  end

  // identity, header and running checksums
  fsk_fmt_crc #(.W(6), .POLY(SID_POLY)) u_sid (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_clear(go && op == `CMD_STATION), .i_init(bus.init_sid),
    .i_en(crc_fold && op_r == `CMD_STATION), .i_byte(plain), .o_crc(sid_crc));
  fsk_fmt_crc #(.W(16), .POLY(HDR_POLY)) u_hdr (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_clear(go && op == `CMD_HEADER), .i_init(bus.init_hdr),
    .i_en(crc_fold && op_r == `CMD_HEADER), .i_byte(plain), .o_crc(hdr_crc));
  fsk_fmt_crc #(.W(32), .POLY(PAY_POLY)) u_pay (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_clear(restart), .i_init(bus.init_pay),
    .i_en(crc_fold && (op_r == `CMD_INTER || op_r == `CMD_LAST)), .i_byte(plain),
    .o_crc(pay_crc));

  assign o_air_valid = air_v_r;
  assign o_air_data = air_d_r;
  assign bus.d2h_valid = host_v_r;
  assign bus.d2h_data = host_d_r;
  assign bus.d2h_last = host_l_r;
  assign bus.crc_done = done_r;
  assign bus.crc_pass = pass_r;
  assign bus.cmd_err = err_r;
  assign o_code_rate = rate_r;
  assign o_legacy = leg_r;
endmodule : fsk_fmt_dev

// ===== fsk_fmt_host.sv
// host end of the fsk block formatter: register port to block commands and bytes
`include "fsk_fmt_defs.svh"
module fsk_fmt_host (
  input wire logic i_sys_clk, // system clock
  input wire logic i_reset, // sync reset, active high
  input wire logic i_ce, // clock enable
  input wire logic [3:0] i_addr, // register word address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after strobe
  fsk_fmt_if.host bus // formatter link
);
  logic [1:0] mod_r;
  logic [15:0] cmd_r;
  logic cmd_pend_r, tx_full_r, rx_full_r, rx_last_r, seen_r, pass_r, err_r;
  logic [7:0] tx_d_r, rx_d_r;
  logic [5:0] init_sid_r;
  logic [15:0] init_hdr_r;
  logic [31:0] init_pay_r;
  logic [31:0] rdata_r;

  // write and read decode
  wire wr_ctrl = i_ce && i_wr && i_addr == `REG_CTRL;
  wire wr_cmd = i_ce && i_wr && i_addr == `REG_CMD && !cmd_pend_r;
  wire wr_txd = i_ce && i_wr && i_addr == `REG_TXD && !tx_full_r;
  wire rd_rxd = i_ce && i_rd && i_addr == `REG_RXD;
  wire rd_stat = i_ce && i_rd && i_addr == `REG_STAT;
  wire take_rx = i_ce && bus.d2h_valid && !rx_full_r;
  wire [31:0] stat = {25'h0, pass_r, seen_r, rx_last_r, rx_full_r, tx_full_r, cmd_pend_r, err_r};
  wire [31:0] rd_mux = (i_addr == `REG_CTRL) ? {30'h0, mod_r}
                     : (i_addr == `REG_CMD) ? {16'h0, cmd_r}
                     : (i_addr == `REG_RXD) ? {24'h0, rx_d_r}
                     : (i_addr == `REG_STAT) ? stat
                     : (i_addr == `REG_INIT_SID) ? {26'h0, init_sid_r}
                     : (i_addr == `REG_INIT_HDR) ? {16'h0, init_hdr_r}
                     : (i_addr == `REG_INIT_PAY) ? init_pay_r : 32'h0;

  // configuration and checksum start values, zero after reset
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      mod_r <= 2'h0;
      init_sid_r <= 6'(`INIT_RESET);
      init_hdr_r <= 16'(`INIT_RESET);
      init_pay_r <= `INIT_RESET;
    end
    else if (i_ce && i_wr)
    begin
      if (wr_ctrl)
        mod_r <= i_wdata[1:0];
      if (i_addr == `REG_INIT_SID)
        init_sid_r <= i_wdata[5:0];
      if (i_addr == `REG_INIT_HDR)
        init_hdr_r <= i_wdata[15:0];
      if (i_addr == `REG_INIT_PAY)
        init_pay_r <= i_wdata;
    end
  end

  // command and byte holding registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      {cmd_r, cmd_pend_r, tx_full_r, tx_d_r, rx_full_r, rx_d_r, rx_last_r} <= '0;
    else if (i_ce)
    begin
      if (wr_cmd)
        {cmd_r, cmd_pend_r} <= {i_wdata[15:0], 1'b1};
      else if (bus.cmd_ready)
        cmd_pend_r <= 1'b0;
      if (wr_txd)
        {tx_d_r, tx_full_r} <= {i_wdata[7:0], 1'b1};
      else if (bus.h2d_ready)
        tx_full_r <= 1'b0;
      if (take_rx)
        {rx_d_r, rx_last_r, rx_full_r} <= {bus.d2h_data, bus.d2h_last, 1'b1};
      else if (rd_rxd)
        rx_full_r <= 1'b0;
    end
  end

  // sticky flags: a new event wins over the read that clears
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      {seen_r, pass_r, err_r, rdata_r} <= '0;
    else if (i_ce)
    begin
      seen_r <= bus.crc_done | (seen_r & !rd_stat);
      if (bus.crc_done)
        pass_r <= bus.crc_pass;
      err_r <= bus.cmd_err | (err_r & !rd_stat);
      rdata_r <= i_rd ? rd_mux : 32'h0;
    end
  end

  assign bus.cmd_valid = cmd_pend_r;
  assign bus.cmd_word = cmd_r;
  assign bus.mod_sel = fsk_fmt_pkg::mod_t'(mod_r);
  assign bus.init_sid = init_sid_r;
  assign bus.init_hdr = init_hdr_r;
  assign bus.init_pay = init_pay_r;
  assign bus.h2d_valid = tx_full_r;
  assign bus.h2d_data = tx_d_r;
  assign bus.d2h_ready = !rx_full_r;
  assign o_rdata = rdata_r;
endmodule : fsk_fmt_host

// ===== fsk_block_formatter_chk.sv
// assertions on the link between the host end and the modem end
module fsk_block_formatter_chk (
  input wire logic i_sys_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic cmd_valid, // command offered
  input wire logic cmd_ready, // command taken
  input wire logic [15:0] cmd_word, // command
  input wire fsk_fmt_pkg::mod_t mod_sel, // modulation
  input wire logic h2d_ready, // tx byte taken
  input wire logic d2h_valid, // rx byte offered
  input wire logic d2h_ready, // rx byte taken
  input wire logic [7:0] d2h_data, // rx byte
  input wire logic crc_done, // check finished
  input wire logic crc_pass, // check result
  input wire logic cmd_err // command refused
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // command decode
  wire take = cmd_valid && cmd_ready;
  wire [3:0] op = cmd_word[15:12];
  wire [3:0] typ = cmd_word[11:8];
  wire blk = (op >= 4'h4) && (op <= 4'h7);
  wire legacy = blk && ((typ == 4'h3) || (op == 4'h4));
  wire native = blk && (op != 4'h4) && (typ <= 4'hb) && (typ != 4'h3);
  legacy_refuse_a: assert property (
    take && legacy && mod_sel != fsk_fmt_pkg::MOD_4FSK |=> cmd_err)
    else $error("legacy block accepted off 4-level");
  type_refuse_a: assert property (
    take && blk && op != 4'h4 && typ > 4'hb |=> cmd_err)
    else $error("unknown block type accepted");
  op_refuse_a: assert property (
    take && (op < 4'h4 || op > 4'h8) |=> cmd_err)
    else $error("unknown command accepted");
  native_ok_a: assert property (
    take && native |=> !cmd_err)
    else $error("native block refused");
  busy_hold_a: assert property (
    take && native |=> !cmd_ready [*2])
    else $error("command taken while block open");
  err_cause_a: assert property (
    cmd_err |-> $past(take) && !$past(cmd_err))
    else $error("refusal without command");
  crc_pulse_a: assert property (
    crc_done |=> !crc_done)
    else $error("check flag longer than one cycle");
  idle_bytes_a: assert property (
    cmd_ready |-> !h2d_ready)
    else $error("payload byte taken with no block open");
  rx_hold_a: assert property (
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("received byte dropped while stalled");
  // main scenarios
  cover property (take && legacy && mod_sel != fsk_fmt_pkg::MOD_4FSK);
  cover property (crc_done && crc_pass);
  cover property (crc_done && !crc_pass);
endmodule : fsk_block_formatter_chk

// ===== fsk_block_formatter_tb.sv
// bench for the fsk block formatter: host and modem ends joined back to back
module fsk_block_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk;
  logic i_reset;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic air_v;
  logic [7:0] air_d;
  logic air_r = 1'b0;
  fsk_fmt_pkg::rate_t rate;
  logic leg;
  logic rx_v;
  logic [7:0] rx_d;
  logic rx_r;
  logic [7:0] airq[$];
  logic [31:0] s;
  logic seen;
  logic pas;
  logic [15:0] bad [5] = '{16'h5300, 16'h4000, 16'h5c00, 16'h3000, 16'h9000};
  int fails;
  int total_checks;
  int cyc = 0;
  fsk_fmt_if bus ();
  fsk_fmt_host i_fsk_fmt_host (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .bus(bus.host));
  fsk_fmt_dev i_fsk_fmt_dev (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
    .bus(bus.dev), .o_air_valid(air_v), .o_air_data(air_d), .i_air_ready(air_r),
    .i_air_valid(rx_v), .i_air_data(rx_d), .o_air_ready(rx_r), .o_code_rate(rate), .o_legacy(leg));
  fsk_block_formatter_chk i_fsk_block_formatter_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .cmd_valid(bus.cmd_valid), .cmd_ready(bus.cmd_ready), .cmd_word(bus.cmd_word),
    .mod_sel(bus.mod_sel), .h2d_ready(bus.h2d_ready), .d2h_valid(bus.d2h_valid),
    .d2h_ready(bus.d2h_ready), .d2h_data(bus.d2h_data), .crc_done(bus.crc_done),
    .crc_pass(bus.crc_pass), .cmd_err(bus.cmd_err));
  // clock, 40 ns period
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // capture coded tx bytes; the modulator stalls one cycle in four
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    air_r <= (cyc % 4 != 3);
    if (air_v && air_r)
      airq.push_back(air_d);
  end
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tmo(input string nm);
    chk(nm, 32'h1, 32'h0);
    test_done();
  endtask : tmo
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask : wreg
  // read strobe for one cycle, data taken in the cycle after it
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    @(negedge i_sys_clk);
    d = rdata;
    if (a == 4'h4 && d[5] === 1'b1)
    begin
      seen = 1'b1;
      pas = d[6];
    end
  endtask : rreg
  task automatic poll(input int b, input logic v);
    rreg(4'h4, s);
    for (int n = 0; s[b] !== v; n++)
    begin
      if (n > 400)
        tmo("status wait");
      rreg(4'h4, s);
    end
  endtask : poll
  // one tx block: command, n payload bytes, then nair coded bytes expected on air
  task automatic tx_blk(input logic [15:0] c, input int n, input int nair);
    int k;
    poll(1, 1'b0);
    k = airq.size() + nair;
    wreg(4'h1, {16'h0, c});
    for (int i = 0; i < n; i++)
    begin
      poll(2, 1'b0);
      wreg(4'h2, 32'h30 + i);
    end
    for (int t = 0; t < 300 && airq.size() < k; t++)
      @(posedge i_sys_clk);
    repeat (8) @(posedge i_sys_clk);
    chk("coded byte count", k, airq.size());
  endtask : tx_blk
  // one rx block replayed from captured air bytes; crc 0 none, 1 pass, 2 fail
  task automatic rx_blk(input logic [15:0] c, input int from, input int n, input int nu,
    input logic [7:0] flip, input int crc);
    poll(1, 1'b0);
    seen = 1'b0;
    wreg(4'h1, {16'h0, c | 16'h0080});
    fork
      for (int i = 0; i < n; i++)
      begin
        rx_v <= 1'b1;
        rx_d <= airq[from + i] ^ ((i == n - 1) ? flip : 8'h00);
        for (int t = 0; t <= 300; t++)
        begin
          @(negedge i_sys_clk);
          if (rx_r === 1'b1)
            break;
          if (t == 300)
            tmo("air ready");
        end
        @(posedge i_sys_clk);
      end
      for (int i = 0; i < nu; i++)
      begin
        poll(3, 1'b1);
        chk("rx last flag", i == nu - 1, s[4]);
        rreg(4'h3, s);
        chk("rx byte", 32'h30 + i, s);
      end
    join
    rx_v <= 1'b0;
    for (int t = 0; t < 40 && !seen; t++)
      rreg(4'h4, s);
    chk("check flag", crc != 0, seen);
    if (crc != 0)
      chk("check result", crc == 1, pas);
  endtask : rx_blk
  // main sequence
  initial
  begin
    i_reset = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    rx_v = 1'b0;
    rx_d = 8'h00;
    seen = 1'b0;
    pas = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rreg(4'h4, s);
    chk("status after reset", 32'h0, s);
    rreg(4'h9, s);
    chk("unmapped read", 32'h0, s);
    // checksum start values set to zero before any block
    for (int a = 5; a < 8; a++)
      wreg(4'(a), 32'h0);
    wreg(4'h0, 32'h1);
    foreach (bad[i])
    begin
      wreg(4'h1, {16'h0, bad[i]});
      repeat (4) @(posedge i_sys_clk);
      rreg(4'h4, s);
      chk("refusal flag", 32'h1, s[0]);
    end
    rreg(4'h4, s);
    chk("refusal flag cleared", 32'h0, s[0]);
    // header type 0 in each modulation: sync grows with bits per symbol
    for (int m = 0; m < 3; m++)
    begin
      wreg(4'h0, m);
      tx_blk(16'h5000, 4, 12 + 3 * m);
      chk("code rate", (m == 1) ? fsk_fmt_pkg::RATE_2_3 : fsk_fmt_pkg::RATE_3_4, rate);
    end
    chk("first sync byte", 8'h55, airq[$ - 17]);
    tx_blk(16'h5b00, 46, 60);
    chk("code rate", fsk_fmt_pkg::RATE_9_16, rate);
    chk("legacy flag", 32'h0, leg);
    tx_blk(16'h6000, 6, 6);
    wreg(4'h0, 32'h0);
    airq.delete();
    tx_blk(16'h8000, 0, 0);
    tx_blk(16'h5000, 4, 12);
    tx_blk(16'h6000, 6, 6);
    tx_blk(16'h7000, 2, 6);
    tx_blk(16'h8000, 0, 0);
    rx_blk(16'h5000, 6, 6, 4, 8'h00, 1);
    rx_blk(16'h5000, 6, 6, 4, 8'h01, 2);
    rx_blk(16'h6000, 12, 6, 6, 8'h00, 0);
    rx_blk(16'h7000, 18, 6, 2, 8'h00, 1);
    tx_blk(16'h8000, 0, 0);
    rx_blk(16'h7000, 18, 6, 2, 8'h00, 2);
    // legacy frames: symbol sync only at the start of a transmission
    airq.delete();
    tx_blk(16'h4000, 4, 15);
    chk("symbol sync byte", 8'h77, airq[0]);
    chk("legacy flag", 32'h1, leg);
    tx_blk(16'h4000, 4, 11);
    tx_blk(16'h5300, 11, 13);
    tx_blk(16'h7340, 9, 13);
    tx_blk(16'h4000, 4, 15);
    rx_blk(16'h4000, 10, 5, 4, 8'h00, 1);
    rx_blk(16'h5300, 26, 13, 11, 8'h00, 1);
    rx_blk(16'h5300, 26, 13, 11, 8'h04, 2);
    test_done();
  end
endmodule : fsk_block_formatter_tb
